/* File: logic/lfd_fetch.sv */
// Purpose: frame buffer fetch engine with apb registers
// Assumes: memory bus with grant, valid and error per word
// Notes:   status bits ber and fifo flags clear by writing 1
//
// The implementer's own choice: the APB register port.
module lfd_fetch
  import lfd_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             mem_req,
  output logic             mem_top_prio,
  output logic             mem_lock,
  output logic             mem_incr,
  output logic [31:0]      mem_addr,
  input  wire logic        mem_gnt,
  input  wire logic        mem_valid,
  input  wire logic        mem_err,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        up_rd,
  output logic [31:0]      up_data,
  input  wire logic        lo_rd,
  output logic [31:0]      lo_data,
  output logic             pal_we,
  output logic [7:0]       pal_addr,
  output logic [31:0]      pal_data,
  output logic             irq
);
  logic [31:0] base_ff [2];
  logic [31:0] ptr_ff  [2];
  logic [31:0] end_ff  [2];
  logic [31:0] ctrl_ff;
  logic [31:0] size_ff;
  logic [31:0] status_ff;
  logic [1:0]  depth_ff;
  logic        en_q_ff;
  lfd_state_t  state_ff;
  logic        ch_ff;
  logic [1:0]  beat_ff;
  logic [8:0]  pal_cnt_ff;
  logic        pal_on_ff;
  logic        pal_we_ff;
  logic [7:0]  pal_addr_ff;
  logic [31:0] pal_data_ff;
  logic        apb_wr;
  logic        apb_rd;
  logic        en_rise;
  logic        dual;
  logic [1:0]  room;
  logic [1:0]  ovr;
  logic [1:0]  unr;
  logic [1:0]  fifo_wr;
  logic [31:0] word;
  logic        beat_ok;
  logic [31:0] rd_mux;
  logic [31:0] up_q;
  logic [31:0] lo_q;
  logic [31:0] nxt_ptr;
  logic        at_end;
  logic        fifo_flush;

  // bytes per panel from size and depth settings
  function automatic logic [31:0] frame_bytes(input logic [31:0] sz,
                                              input logic [31:0] ct,
                                              input logic [1:0]  dc);
    logic [31:0] pix;
    logic [31:0] bits;
    pix = (32'(sz[SZ_PPR_LSB +: SZ_W]) + 32'h1)
        * (32'(sz[SZ_RPP_LSB +: SZ_W]) + 32'h1);
    if (ct[CTL_BW]) begin
      bits = ct[CTL_M8B] ? (pix << 3) : (pix << 2);
    end else begin
      unique case (dc)
        2'h0:    bits = pix << 2;
        2'h1:    bits = pix << 3;
        2'h2:    bits = pix << 4;
        default: bits = pix << 4;
      endcase
    end
    frame_bytes = bits >> 3;
  endfunction

  function automatic logic [31:0] palette_bytes(input logic [1:0] dc);
    palette_bytes = (dc == 2'h0) ? 32'h0000_0020 : 32'h0000_0200;
  endfunction

  assign apb_wr     = psel && penable && pwrite;
  assign apb_rd     = psel && !pwrite;
  assign dual       = ctrl_ff[CTL_DP];
  assign en_rise    = ctrl_ff[CTL_EN] && !en_q_ff;
  assign fifo_flush = !ctrl_ff[CTL_EN];
  assign word       = mem_err ? 32'h0000_0000 : mem_rdata;
  assign beat_ok    = (state_ff == ST_DATA) && mem_valid;
  assign nxt_ptr    = ptr_ff[ch_ff] + WORD_STEP;
  assign at_end     = nxt_ptr == end_ff[ch_ff];
  // palette words are not pixel data
  assign fifo_wr[0] = beat_ok && !ch_ff && !pal_on_ff;
  assign fifo_wr[1] = beat_ok && ch_ff;

  lfd_infifo u_up (
    .pclk     (pclk),
    .presetn  (presetn),
    .flush    (fifo_flush),
    .wr_en    (fifo_wr[0]),
    .wr_data  (word),
    .rd_en    (up_rd),
    .rd_data  (up_q),
    .room4    (room[0]),
    .overrun  (ovr[0]),
    .underrun (unr[0])
  );

  lfd_infifo u_lo (
    .pclk     (pclk),
    .presetn  (presetn),
    .flush    (fifo_flush),
    .wr_en    (fifo_wr[1]),
    .wr_data  (word),
    .rd_en    (lo_rd && dual),
    .rd_data  (lo_q),
    .room4    (room[1]),
    .overrun  (ovr[1]),
    .underrun (unr[1])
  );

  // apb: zero wait states
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      OFF_C1_BASE: rd_mux = base_ff[0];
      OFF_C2_BASE: rd_mux = base_ff[1];
      OFF_C1_PTR:  rd_mux = ptr_ff[0];
      OFF_C2_PTR:  rd_mux = ptr_ff[1];
      OFF_CTRL:    rd_mux = ctrl_ff;
      OFF_SIZE:    rd_mux = size_ff;
      OFF_STATUS:  rd_mux = status_ff;
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (apb_rd && !penable) begin
        prdata <= rd_mux;
      end
    end
  end

  // base registers hold no reset value
  always_ff @(posedge pclk) begin
    if (apb_wr && pready && paddr == OFF_C1_BASE) begin
      base_ff[0] <= {pwdata[31:2], 2'b00};
    end
    if (apb_wr && pready && paddr == OFF_C2_BASE) begin
      base_ff[1] <= {pwdata[31:2], 2'b00};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= 32'h0000_0000;
      size_ff <= 32'h0000_0000;
      en_q_ff <= 1'b0;
    end else begin
      en_q_ff <= ctrl_ff[CTL_EN];
      if (apb_wr && pready && paddr == OFF_CTRL) begin
        ctrl_ff <= {28'h0, pwdata[3:0]};
      end
      if (apb_wr && pready && paddr == OFF_SIZE) begin
        size_ff <= {6'h0, pwdata[25:16], 6'h0, pwdata[9:0]};
      end
    end
  end

  // status: sticky bits, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= STATUS_RST;
    end else begin
      if (apb_wr && pready && paddr == OFF_STATUS) begin
        status_ff[ST_BER]   <= status_ff[ST_BER] & ~pwdata[ST_BER];
        status_ff[ST_UPIOR] <= status_ff[ST_UPIOR] & ~pwdata[ST_UPIOR];
        status_ff[ST_UPIUR] <= status_ff[ST_UPIUR] & ~pwdata[ST_UPIUR];
        status_ff[ST_LPIOR] <= status_ff[ST_LPIOR] & ~pwdata[ST_LPIOR];
        status_ff[ST_LPIUR] <= status_ff[ST_LPIUR] & ~pwdata[ST_LPIUR];
      end
      if (apb_wr && pready && (paddr == OFF_C1_BASE ||
          (dual && paddr == OFF_C2_BASE))) begin
        status_ff[ST_NEXT] <= 1'b0;
      end
      if (en_rise || (beat_ok && at_end && !ch_ff)) begin
        status_ff[ST_NEXT] <= 1'b1;
      end
      if (beat_ok && mem_err) begin
        status_ff[ST_BER] <= 1'b1;
      end
      if (ovr[0]) status_ff[ST_UPIOR] <= 1'b1;
      if (unr[0]) status_ff[ST_UPIUR] <= 1'b1;
      if (ovr[1]) status_ff[ST_LPIOR] <= 1'b1;
      if (unr[1]) status_ff[ST_LPIUR] <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= status_ff[ST_NEXT] | status_ff[ST_BER];
    end
  end

  // current pointers: no reset, loaded on enable
  always_ff @(posedge pclk) begin
    if (en_rise) begin
      ptr_ff[0] <= base_ff[0];
      ptr_ff[1] <= base_ff[1];
      end_ff[0] <= base_ff[0] + frame_bytes(size_ff, ctrl_ff, 2'h0);
      end_ff[1] <= base_ff[1] + frame_bytes(size_ff, ctrl_ff, 2'h0);
    end else if (beat_ok) begin
      if (at_end) begin
        ptr_ff[ch_ff] <= base_ff[ch_ff];
      end else begin
        ptr_ff[ch_ff] <= nxt_ptr;
      end
      if (!ch_ff && pal_on_ff && pal_cnt_ff == 9'h0) begin
        // first palette word sets depth and end
        end_ff[0] <= base_ff[0] + frame_bytes(size_ff, ctrl_ff,
                       word[DEPTH_LSB +: DEPTH_W]) + palette_bytes(
                       word[DEPTH_LSB +: DEPTH_W]);
        end_ff[1] <= base_ff[1] + frame_bytes(size_ff, ctrl_ff,
                       word[DEPTH_LSB +: DEPTH_W]);
      end
    end
  end

  // palette phase of channel one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pal_on_ff   <= 1'b0;
      pal_cnt_ff  <= 9'h0;
      depth_ff    <= 2'h0;
      pal_we_ff   <= 1'b0;
      pal_addr_ff <= 8'h00;
      pal_data_ff <= 32'h0000_0000;
    end else begin
      pal_we_ff <= 1'b0;
      if (en_rise || (beat_ok && at_end && !ch_ff)) begin
        pal_on_ff  <= 1'b1;
        pal_cnt_ff <= 9'h0;
      end else if (fifo_wr[0] == 1'b0 && beat_ok && !ch_ff && pal_on_ff) begin
        pal_we_ff   <= 1'b1;
        pal_addr_ff <= pal_cnt_ff[7:0];
        pal_data_ff <= word;
        pal_cnt_ff  <= pal_cnt_ff + 9'h1;
        if (pal_cnt_ff == 9'h0) begin
          depth_ff <= word[DEPTH_LSB +: DEPTH_W];
        end
        // two 16-bit entries per word
        if (pal_cnt_ff + 9'h1 ==
            ((pal_cnt_ff == 9'h0 ? word[DEPTH_LSB +: DEPTH_W] : depth_ff)
             == 2'h0 ? 9'h008 : 9'h080)) begin
          pal_on_ff <= 1'b0;
        end
      end
    end
  end

  // burst sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
      ch_ff    <= 1'b0;
      beat_ff  <= 2'h0;
      mem_req  <= 1'b0;
      mem_lock <= 1'b0;
      mem_addr <= 32'h0000_0000;
    end else if (!ctrl_ff[CTL_EN] || en_rise) begin
      state_ff <= ST_IDLE;
      mem_req  <= 1'b0;
      mem_lock <= 1'b0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (room[0] || pal_on_ff) begin
            ch_ff    <= 1'b0;
            state_ff <= ST_REQ;
            mem_req  <= 1'b1;
            mem_addr <= ptr_ff[0];
          end else if (dual && room[1]) begin
            ch_ff    <= 1'b1;
            state_ff <= ST_REQ;
            mem_req  <= 1'b1;
            mem_addr <= ptr_ff[1];
          end
        end
        ST_REQ: begin
          if (mem_gnt) begin
            mem_lock <= 1'b1;
            beat_ff  <= 2'h0;
            state_ff <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (mem_valid) begin
            beat_ff <= beat_ff + 2'h1;
            if (beat_ff == 2'(BURST_LEN - 1)) begin
              mem_req  <= 1'b0;
              mem_lock <= 1'b0;
              state_ff <= ST_IDLE;
            end
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_top_prio <= 1'b0;
      mem_incr     <= 1'b0;
      up_data      <= 32'h0000_0000;
      lo_data      <= 32'h0000_0000;
    end else begin
      mem_top_prio <= 1'b1;
      mem_incr     <= 1'b1;
      up_data      <= up_q;
      lo_data      <= lo_q;
    end
  end

  assign pal_we   = pal_we_ff;
  assign pal_addr = pal_addr_ff;
  assign pal_data = pal_data_ff;
endmodule // lfd_fetch

/* File: inc/lfd_pkg.sv */
// Purpose: constants for the frame buffer fetch engine
// Assumes: apb register bus, 32-bit words
// Notes:   offsets are byte addresses
package lfd_pkg;
  localparam logic [7:0] OFF_C1_BASE   = 8'h10;
  localparam logic [7:0] OFF_C2_BASE   = 8'h14;
  localparam logic [7:0] OFF_C1_PTR    = 8'h18;
  localparam logic [7:0] OFF_C2_PTR    = 8'h1c;
  localparam logic [7:0] OFF_CTRL      = 8'h20;
  localparam logic [7:0] OFF_SIZE      = 8'h24;
  localparam logic [7:0] OFF_STATUS    = 8'h28;
  // control fields
  localparam int CTL_EN   = 0;
  localparam int CTL_DP   = 1;
  localparam int CTL_BW   = 2;
  localparam int CTL_M8B  = 3;
  // size fields: pixels per row [9:0], rows per panel [25:16]
  localparam int SZ_PPR_LSB = 0;
  localparam int SZ_RPP_LSB = 16;
  localparam int SZ_W       = 10;
  // status fields
  localparam int ST_NEXT  = 1;
  localparam int ST_BER   = 2;
  localparam int ST_LPIOR = 4;
  localparam int ST_LPIUR = 5;
  localparam int ST_UPIOR = 6;
  localparam int ST_UPIUR = 7;
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  localparam int BURST_LEN = 4;
  localparam int FIFO_DEPTH = 8;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam int DEPTH_LSB = 1;  // pixel depth code in first palette word
  localparam int DEPTH_W   = 2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ  = 2'b01,
    ST_DATA = 2'b10
  } lfd_state_t;
endpackage

/* File: logic/lfd_infifo.sv */
// Purpose: input word fifo for one panel
// Assumes: single clock, fixed depth
// Notes:   flags overrun and underrun as pulses
module lfd_infifo
  import lfd_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        flush,
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_data,
  input  wire logic        rd_en,
  output logic [31:0]      rd_data,
  output logic             room4,
  output logic             overrun,
  output logic             underrun
);
  logic [31:0] mem [FIFO_DEPTH];
  logic [2:0]  wp_ff;
  logic [2:0]  rp_ff;
  logic [3:0]  cnt_ff;
  logic        do_wr;
  logic        do_rd;

  assign do_wr    = wr_en && (cnt_ff != 4'(FIFO_DEPTH));
  assign do_rd    = rd_en && (cnt_ff != 4'h0);
  assign overrun  = wr_en && !do_wr;
  assign underrun = rd_en && !do_rd;
  assign room4    = (4'(FIFO_DEPTH) - cnt_ff) >= 4'(BURST_LEN);
  assign rd_data  = mem[rp_ff];

  // words enter at the top
  always_ff @(posedge pclk) begin
    if (do_wr) begin
      mem[wp_ff] <= wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_ff  <= 3'h0;
      rp_ff  <= 3'h0;
      cnt_ff <= 4'h0;
    end else if (flush) begin
      wp_ff  <= 3'h0;
      rp_ff  <= 3'h0;
      cnt_ff <= 4'h0;
    end else begin
      if (do_wr) begin
        wp_ff <= wp_ff + 3'h1;
      end
      if (do_rd) begin
        rp_ff <= rp_ff + 3'h1;
      end
      cnt_ff <= cnt_ff + 4'(do_wr) - 4'(do_rd);
    end
  end
endmodule // lfd_infifo

/* File: bench/lfd_fetch_asserts.sv */
// Purpose: port checker for the frame fetch engine
// Assumes: single pclk domain, async active-low reset
// Notes:   bound to every lfd_fetch instance
module lfd_fetch_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        mem_req,
  input wire logic        mem_top_prio,
  input wire logic        mem_lock,
  input wire logic        mem_incr,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_gnt,
  input wire logic        mem_valid,
  input wire logic        mem_err,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [2:0] beat_ff;
  // beats seen while the bus is held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) beat_ff <= 3'h0;
    else if (!mem_lock) beat_ff <= 3'h0;
    else if (mem_valid) beat_ff <= beat_ff + 3'h1;
  end
  AST_TOP_PRIO: assert property ($past(presetn) |-> mem_top_prio)
    else $error("bus priority not highest");
  AST_INCR: assert property (mem_req |-> mem_incr)
    else $error("burst not incrementing");
  AST_LOCK: assert property (mem_req && mem_gnt |=> mem_lock)
    else $error("bus not held after grant");
  AST_LOCK_END: assert property ($fell(mem_lock) |->
    $past(mem_valid) && $past(beat_ff) == 3'h3)
    else $error("bus released before fourth beat");
  AST_REQ_HOLD: assert property (mem_req && !mem_gnt && !mem_lock
    |=> mem_req && $stable(mem_addr))
    else $error("request dropped or moved before grant");
  AST_PREADY: assert property (psel && !penable |=> pready)
    else $error("register access not answered");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_BER_IRQ: assert property (mem_valid && mem_err |-> ##[1:3] irq)
    else $error("bus error gave no interrupt");
endmodule // lfd_fetch_asserts

bind lfd_fetch lfd_fetch_asserts lfd_fetch_asserts_inst (.pclk, .presetn,
  .psel, .penable, .pready, .mem_req, .mem_top_prio, .mem_lock, .mem_incr,
  .mem_addr, .mem_gnt, .mem_valid, .mem_err, .irq);

/* File: bench/lfd_mem_model.sv */
// Purpose: memory side of the fetch bus
// Assumes: grant then four beats, random gaps
// Notes:   data word is address xor a fixed pattern, zeros on an errored beat
module lfd_mem_model (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic        err_en,
  output logic            mem_gnt,
  output logic            mem_valid,
  output logic            mem_err,
  output logic [31:0]     mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] a;
  int          i;
  initial begin
    mem_gnt = 0; mem_valid = 0; mem_err = 0; mem_rdata = 0;
    forever begin
      @(posedge pclk);
      if (presetn && mem_req && !mem_gnt) begin
        a = mem_addr;
        repeat ($urandom_range(0, 2)) @(posedge pclk);
        mem_gnt <= 1;
        @(posedge pclk);
        mem_gnt <= 0;
        for (i = 0; i < 4; i++) begin
          if ($urandom_range(0, 1)) begin
            mem_valid <= 0;
            mem_rdata <= ~mem_rdata;
            @(posedge pclk);
          end
          mem_valid <= 1;
          mem_err   <= err_en && i == 0;
          // errored beat returns zeros
          mem_rdata <= (err_en && i == 0) ? 32'h0 :
                       (a + 32'(4 * i)) ^ 32'h5a5a_0000;
          @(posedge pclk);
        end
        mem_valid <= 0;
        mem_err   <= 0;
        mem_rdata <= ~mem_rdata;
      end
    end
  end
endmodule // lfd_mem_model

/* File: bench/tb_top.sv */
// Purpose: self-checking bench for the frame fetch engine
// Assumes: apb master tasks, memory model partner
// Notes:   large size setting so no wrap occurs
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  import lfd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] PAT = 32'h5a5a_0000;
  logic        pclk, presetn, psel, penable, pwrite, up_rd, lo_rd, err_en;
  logic        pready, pslverr, mem_req, mem_top_prio, mem_lock, mem_incr;
  logic        mem_gnt, mem_valid, mem_err, pal_we, irq;
  logic [7:0]  paddr, pal_addr;
  logic [31:0] pwdata, prdata, mem_addr, mem_rdata, up_data, lo_data;
  logic [31:0] pal_data, b1, b2, r, r2;
  int          errors, compares, gcnt, pcnt, seen2, n, k;
  lfd_fetch lfd_fetch_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_top_prio,
    .mem_lock, .mem_incr, .mem_addr, .mem_gnt, .mem_valid, .mem_err,
    .mem_rdata, .up_rd, .up_data, .lo_rd, .lo_data, .pal_we, .pal_addr,
    .pal_data, .irq);
  lfd_mem_model lfd_mem_model_inst (.pclk, .presetn, .mem_req, .mem_addr,
    .err_en, .mem_gnt, .mem_valid, .mem_err, .mem_rdata);
  initial begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end
  task results;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task tmo;
    errors++;
    results;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q);
    int c;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    c = 0;
    do begin @(posedge pclk); c++; end while (pready !== 1'b1 && c < 50);
    if (c >= 50) tmo;
    q = prdata;
    psel <= 0; penable <= 0;
  endtask
  // wait until fetching has gone quiet
  task settle;
    int c, q;
    c = 0; q = 0;
    while (q < 8 && c < 3000) begin
      @(posedge pclk); c++;
      q = (mem_req || mem_lock) ? 0 : q + 1;
    end
    if (c >= 3000) tmo;
  endtask
  task pop(input logic up);
    @(posedge pclk);
    if (up) up_rd <= 1; else lo_rd <= 1;
    @(posedge pclk);
    up_rd <= 0; lo_rd <= 0;
    repeat (2) @(posedge pclk);
  endtask
  // burst and palette monitor
  always @(posedge pclk) begin
    if (mem_req && mem_gnt) begin
      gcnt++;
      if (mem_addr === b2) seen2++;
    end
    if (pal_we) begin
      `CHK(pal_addr, 8'(pcnt));
      `CHK(pal_data, (b1 + 32'(4 * pcnt)) ^ PAT);
      pcnt++;
    end
  end
  initial begin
    void'($urandom(32'h7b8a));
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
    pwdata = 0; up_rd = 0; lo_rd = 0; err_en = 0; b1 = 0; b2 = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    b1 = $urandom & 32'h7fff_fff0;
    b2 = $urandom & 32'h7fff_fff0;
    apb(1, OFF_C1_BASE, b1, r);
    apb(1, OFF_C2_BASE, b2, r);
    apb(1, OFF_SIZE, 32'h03ff_03ff, r);
    apb(0, OFF_C1_BASE, 0, r); `CHK(r, b1);
    apb(0, OFF_C2_BASE, 0, r); `CHK(r, b2);
    apb(0, 8'h3c, 0, r); `CHK(r, 32'h0);
    `CHK(pslverr, 1'b0);
    gcnt = 0; pcnt = 0;
    apb(1, OFF_CTRL, 32'h1, r);
    settle;
    `CHK(pcnt, 8);
    `CHK(seen2, 0);
    apb(0, OFF_STATUS, 0, r); `CHK(r[ST_NEXT], 1'b1);
    `CHK(irq, 1'b1);
    apb(0, OFF_C1_PTR, 0, r); `CHK(r, b1 + 32'(16 * gcnt));
    apb(1, OFF_C1_PTR, ~r, r2);
    apb(0, OFF_C1_PTR, 0, r2); `CHK(r2, r);
    apb(1, OFF_C1_BASE, b1, r2);
    apb(0, OFF_STATUS, 0, r2); `CHK(r2[ST_NEXT], 1'b0);
    `CHK(irq, 1'b0);
    n = gcnt;
    err_en <= 1;
    for (k = 0; k < 4; k++) begin
      `CHK(up_data, (b1 + 32'(32 + 4 * k)) ^ PAT);
      pop(1);
    end
    settle;
    err_en <= 0;
    `CHK(gcnt, n + 1);
    apb(0, OFF_STATUS, 0, r); `CHK(r[ST_BER], 1'b1);
    `CHK(irq, 1'b1);
    apb(1, OFF_STATUS, 32'h4, r);
    apb(0, OFF_STATUS, 0, r); `CHK(r[ST_BER], 1'b0);
    pop(0);
    apb(0, OFF_STATUS, 0, r); `CHK(r[ST_LPIUR], 1'b0);
    apb(1, OFF_CTRL, 32'h2, r);
    pop(0);
    apb(0, OFF_STATUS, 0, r); `CHK(r[ST_LPIUR], 1'b1);
    pcnt = 0;
    apb(1, OFF_CTRL, 32'h3, r);
    settle;
    `CHK(seen2 != 0, 1'b1);
    `CHK(lo_data, b2 ^ PAT);
    `CHK(pcnt, 8);
    results;
  end
endmodule // tb_top
